// file: logic/dfs_defs.svh
// Purpose: Constants for the drive fault supervision and option settings block.
// Assumes: 125 MHz clock; register offsets are word indexes, byte address is four times the index.
// Notes: Time settings are held in tenths of a second.
// Summary of operation
// - Compare speed against reference, level percent
// - Deviation fault after continuous programmed delay
// - Encoder loss after no pulse for time
// - Communications error selects one of six actions
// - Option fault detected always or running only
// - Option fault action: ramp, coast, fast, alarm
// - Bus error declared after programmed detection delay
// - Network reference optionally allows multi-step references
// - Initialization keeps or restores communication settings
// - Field network node address, 0 to 63
// - Field network speed code, five rates
// - Bus fault auto clears only when enabled
// - Motion network station address, default 21
// - Frame size decoded by network generation
// - Link speed applies to second generation only
// - Two monitor selection words, full 16 bits
// - Fast stop uses dedicated decel; ramp active
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH
`define DFS_IDX_RESET_SEL     12'h36A
`define DFS_IDX_STATION       12'h36B
`define DFS_IDX_FRAME         12'h36C
`define DFS_IDX_LINK_SPEED    12'h36D
`define DFS_IDX_MON_E         12'h36E
`define DFS_IDX_MON_F         12'h36F
`define DFS_IDX_DEV_LEVEL     12'h389
`define DFS_IDX_DEV_DELAY     12'h38A
`define DFS_IDX_ENC_TIME      12'h38D
`define DFS_IDX_COMM_ACT      12'h3A2
`define DFS_IDX_OPT_MODE      12'h3A3
`define DFS_IDX_OPT_ACT       12'h3A4
`define DFS_IDX_BUS_DELAY     12'h3A5
`define DFS_IDX_NET_REF       12'h3A8
`define DFS_IDX_AUTO_RESET    12'h3BB
`define DFS_IDX_NODE          12'h3E6
`define DFS_IDX_FIELD_SPEED   12'h3E7
`define DFS_IDX_IRQ_STATUS    12'h3F0
`define DFS_IDX_IRQ_MASK      12'h3F1
`define DFS_IDX_FAULT_STATE   12'h3F2
`define DFS_IDX_INIT_CMD      12'h3F3
`define DFS_RST_DEV_LEVEL     16'h000A
`define DFS_RST_DEV_DELAY     16'h0005
`define DFS_RST_ENC_TIME      16'h0014
`define DFS_RST_COMM_ACT      16'h0001
`define DFS_RST_OPT_ACT       16'h0001
`define DFS_RST_BUS_DELAY     16'h0014
`define DFS_RST_STATION       16'h0015
`define DFS_MAX_DEV_LEVEL     16'h0032
`define DFS_MAX_TENTHS_10S    16'h0064
`define DFS_MAX_TENTHS_5S     16'h0032
`define DFS_MAX_NODE          16'h003F
`define DFS_MAX_FIELD_SPEED   16'h0004
`define DFS_MAX_COMM_ACT      16'h0005
`define DFS_MAX_ACT           16'h0003
`define DFS_TENTH_NS          100000000
`define DFS_CLOCK_NS          8
`define DFS_TENTH_CYCLES      (`DFS_TENTH_NS / `DFS_CLOCK_NS)
`define DFS_PCT_SCALE         100
`define DFS_IRQ_DEV           0
`define DFS_IRQ_ENC           1
`define DFS_IRQ_OPT           2
`define DFS_IRQ_BUS           3
`define DFS_IRQ_COMM          4
`define DFS_IRQ_BITS          5
`endif

// file: logic/dfs_pkg.sv
// Purpose: Types for the drive fault supervision block.
// Assumes: Constants come from dfs_defs.svh.
// Notes: Stop codes match the action selection encodings.
package dfs_pkg;
  typedef enum logic [2:0] {
    DFS_ACT_RAMP,
    DFS_ACT_COAST,
    DFS_ACT_FAST,
    DFS_ACT_ALARM,
    DFS_ACT_ALARM_PRESET,
    DFS_ACT_ALARM_RAMP
  } dfs_action_type;
  typedef struct packed {
    logic           stop_req;
    dfs_action_type action;
    logic           use_fast_decel;
    logic           alarm;
    logic           run_preset_four;
  } dfs_stop_type;
  typedef struct packed {
    logic [7:0] frame_bytes;
    logic [3:0] link_mbps;
    logic [5:0] node_address;
    logic [2:0] field_speed;
    logic [15:0] station_address;
    logic [15:0] monitor_e;
    logic [15:0] monitor_f;
  } dfs_net_cfg_type;
endpackage

// file: logic/dfs_supervisor.sv
// Purpose: Fault supervision and option network settings with an APB register slave.
// Assumes: Inputs synchronous to CLOCK; speed values share one scale with max frequency.
// Notes: Every APB transfer completes in its first access cycle; out-of-range writes are ignored.
`timescale 1ns/1ns
`include "dfs_defs.svh"
module dfs_supervisor
  import dfs_pkg::*;
#(
  parameter int TENTH_CYCLES = `DFS_TENTH_CYCLES,
  parameter int SPEED_W      = 16
)(
  input  wire logic                 CLOCK,
  input  wire logic                 ARST_N,
  input  wire logic                 CLOCK_EN,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic                      PREADY,
  output logic [31:0]               PRDATA,
  output logic                      PSLVERR,
  input  wire logic [SPEED_W-1:0]   MOTOR_SPEED,
  input  wire logic [SPEED_W-1:0]   FREQ_REFERENCE,
  input  wire logic [SPEED_W-1:0]   MAX_OUTPUT_FREQUENCY,
  input  wire logic                 ENCODER_PULSE,
  input  wire logic                 MOTOR_RUNNING,
  input  wire logic                 OPTION_EXTERNAL_FAULT,
  input  wire logic                 COMM_ERROR,
  input  wire logic                 BUS_ERROR_RAW,
  input  wire logic                 FAULT_RESET,
  input  wire logic                 NET_REF_ACTIVE,
  input  wire logic                 MULTI_STEP_REQ,
  input  wire logic                 SECOND_GEN,
  output logic                      SPEED_DEVIATION_FAULT,
  output logic                      ENCODER_LOSS_FAULT,
  output logic                      BUS_FAULT,
  output dfs_stop_type              STOP_CMD,
  output logic                      MULTI_STEP_ENABLE,
  output dfs_net_cfg_type           NET_CFG,
  output logic                      IRQ
);
  // The timer width and the deviation product are sized for these ranges only.
  if (TENTH_CYCLES < 1 || SPEED_W < 8 || SPEED_W > 24)
  begin : g_param_check
    $error("dfs_supervisor: unsupported parameter values");
  end

  localparam int TW = 36;
  logic [15:0] dev_level, dev_delay, enc_time, comm_act, opt_mode, opt_act, bus_delay;
  logic [15:0] net_ref, reset_sel, node, field_speed, auto_reset, station, frame, link_speed;
  logic [15:0] mon_e, mon_f;
  logic [`DFS_IRQ_BITS-1:0] irq_status, irq_mask, irq_event;
  logic [TW-1:0] dev_cnt, enc_cnt, bus_cnt;
  logic        dev_excess, opt_fault_seen, comm_fault, opt_fault;
  logic        wr_go, rd_go, init_cmd;
  logic [11:0] idx;
  logic [15:0] wd;
  logic [31:0] next_prdata;
  logic [SPEED_W-1:0] diff;
  logic [SPEED_W+7:0] lhs;
  logic [SPEED_W+7:0] rhs;

  assign idx   = PADDR[11:0] >> 2;
  assign wd    = PWDATA[15:0];
  assign wr_go = CLOCK_EN && PSEL && PENABLE && PWRITE;
  assign rd_go = CLOCK_EN && PSEL && !PENABLE && !PWRITE;
  assign init_cmd = wr_go && idx == `DFS_IDX_INIT_CMD && wd[0];

  // Deviation test: |speed - ref| * 100 > level * max, avoiding a divider.
  assign diff = (MOTOR_SPEED > FREQ_REFERENCE) ? MOTOR_SPEED - FREQ_REFERENCE
                                               : FREQ_REFERENCE - MOTOR_SPEED;
  assign lhs  = (SPEED_W+8)'(diff) * (SPEED_W+8)'(`DFS_PCT_SCALE);
  assign rhs  = (SPEED_W+8)'(dev_level[5:0]) * (SPEED_W+8)'(MAX_OUTPUT_FREQUENCY);
  assign dev_excess = lhs > rhs;

  // Settings; init with reset select 1 restores communication settings.
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      dev_level <= `DFS_RST_DEV_LEVEL;
      dev_delay <= `DFS_RST_DEV_DELAY;
      enc_time  <= `DFS_RST_ENC_TIME;
      comm_act  <= `DFS_RST_COMM_ACT;
      opt_mode  <= '0;
      opt_act   <= `DFS_RST_OPT_ACT;
      bus_delay <= `DFS_RST_BUS_DELAY;
      net_ref   <= '0;
      reset_sel <= '0;
      node      <= '0;
      field_speed <= '0;
      auto_reset <= '0;
      station   <= `DFS_RST_STATION;
      frame     <= '0;
      link_speed <= '0;
      mon_e     <= '0;
      mon_f     <= '0;
      irq_mask  <= '0;
    end
    else if (init_cmd && reset_sel[0])
    begin
      comm_act  <= `DFS_RST_COMM_ACT;
      opt_mode  <= '0;
      opt_act   <= `DFS_RST_OPT_ACT;
      bus_delay <= `DFS_RST_BUS_DELAY;
      net_ref   <= '0;
      reset_sel <= '0;
      node      <= '0;
      field_speed <= '0;
      auto_reset <= '0;
      station   <= `DFS_RST_STATION;
      frame     <= '0;
      link_speed <= '0;
      mon_e     <= '0;
      mon_f     <= '0;
    end
    else if (wr_go)
    begin
      case (idx)
        `DFS_IDX_DEV_LEVEL:   if (wd <= `DFS_MAX_DEV_LEVEL) dev_level <= wd;
        `DFS_IDX_DEV_DELAY:   if (wd <= `DFS_MAX_TENTHS_10S) dev_delay <= wd;
        `DFS_IDX_ENC_TIME:    if (wd <= `DFS_MAX_TENTHS_10S) enc_time <= wd;
        `DFS_IDX_COMM_ACT:    if (wd <= `DFS_MAX_COMM_ACT) comm_act <= wd;
        `DFS_IDX_OPT_MODE:    if (wd[15:1] == '0) opt_mode <= wd;
        `DFS_IDX_OPT_ACT:     if (wd <= `DFS_MAX_ACT) opt_act <= wd;
        `DFS_IDX_BUS_DELAY:   if (wd <= `DFS_MAX_TENTHS_5S) bus_delay <= wd;
        `DFS_IDX_NET_REF:     if (wd[15:1] == '0) net_ref <= wd;
        `DFS_IDX_RESET_SEL:   if (wd[15:1] == '0) reset_sel <= wd;
        `DFS_IDX_NODE:        if (wd <= `DFS_MAX_NODE) node <= wd;
        `DFS_IDX_FIELD_SPEED: if (wd <= `DFS_MAX_FIELD_SPEED) field_speed <= wd;
        `DFS_IDX_AUTO_RESET:  if (wd[15:1] == '0) auto_reset <= wd;
        `DFS_IDX_STATION:     station <= wd;
        `DFS_IDX_FRAME:       if (wd[15:1] == '0) frame <= wd;
        `DFS_IDX_LINK_SPEED:  if (wd[15:1] == '0) link_speed <= wd;
        `DFS_IDX_MON_E:       mon_e <= wd;
        `DFS_IDX_MON_F:       mon_f <= wd;
        `DFS_IDX_IRQ_MASK:    irq_mask <= wd[`DFS_IRQ_BITS-1:0];
        default:              ;
      endcase
    end
  end

  // Delay timers; a zero setting faults on the first qualifying cycle.
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      dev_cnt <= '0;
      SPEED_DEVIATION_FAULT <= 1'b0;
    end
    else if (CLOCK_EN)
    begin
      if (!dev_excess || FAULT_RESET)
      begin
        dev_cnt <= '0;
        SPEED_DEVIATION_FAULT <= SPEED_DEVIATION_FAULT && !FAULT_RESET;
      end
      else if (dev_cnt >= TW'(dev_delay) * TW'(TENTH_CYCLES))
        SPEED_DEVIATION_FAULT <= 1'b1;
      else
        dev_cnt <= dev_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      enc_cnt <= '0;
      ENCODER_LOSS_FAULT <= 1'b0;
    end
    else if (CLOCK_EN)
    begin
      if (ENCODER_PULSE || FAULT_RESET)
      begin
        enc_cnt <= '0;
        ENCODER_LOSS_FAULT <= ENCODER_LOSS_FAULT && !FAULT_RESET;
      end
      else if (enc_cnt >= TW'(enc_time) * TW'(TENTH_CYCLES))
        ENCODER_LOSS_FAULT <= 1'b1;
      else
        enc_cnt <= enc_cnt + 1'b1;
    end
  end

  // Auto reset clears the bus fault once the raw error goes away.
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      bus_cnt <= '0;
      BUS_FAULT <= 1'b0;
    end
    else if (CLOCK_EN)
    begin
      if (!BUS_ERROR_RAW)
      begin
        bus_cnt <= '0;
        if (FAULT_RESET || auto_reset[0])
          BUS_FAULT <= 1'b0;
      end
      else if (bus_cnt >= TW'(bus_delay) * TW'(TENTH_CYCLES))
        BUS_FAULT <= 1'b1;
      else
        bus_cnt <= bus_cnt + 1'b1;
    end
  end

  assign opt_fault_seen = OPTION_EXTERNAL_FAULT && (!opt_mode[0] || MOTOR_RUNNING);

  // Stop command: option fault outranks a communications error.
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      opt_fault <= 1'b0;
      comm_fault <= 1'b0;
      STOP_CMD <= '0;
    end
    else if (CLOCK_EN)
    begin
      // A fault that arrives in the reset cycle is kept, so no event is lost.
      opt_fault  <= opt_fault_seen || (opt_fault && !FAULT_RESET);
      comm_fault <= COMM_ERROR || (comm_fault && !FAULT_RESET);
      STOP_CMD   <= '0;
      if (opt_fault || opt_fault_seen)
      begin
        STOP_CMD.action         <= dfs_action_type'(opt_act[2:0]);
        STOP_CMD.stop_req       <= opt_act[1:0] != 2'h3;
        STOP_CMD.alarm          <= opt_act[1:0] == 2'h3;
        STOP_CMD.use_fast_decel <= opt_act[1:0] == 2'h2;
      end
      else if (comm_fault || COMM_ERROR)
      begin
        STOP_CMD.action <= dfs_action_type'(comm_act[2:0]);
        case (dfs_action_type'(comm_act[2:0]))
          DFS_ACT_RAMP:         STOP_CMD.stop_req <= 1'b1;
          DFS_ACT_COAST:        STOP_CMD.stop_req <= 1'b1;
          DFS_ACT_FAST:
          begin
            STOP_CMD.stop_req <= 1'b1;
            STOP_CMD.use_fast_decel <= 1'b1;
          end
          DFS_ACT_ALARM:        STOP_CMD.alarm <= 1'b1;
          DFS_ACT_ALARM_PRESET:
          begin
            STOP_CMD.alarm <= 1'b1;
            STOP_CMD.run_preset_four <= 1'b1;
          end
          DFS_ACT_ALARM_RAMP:
          begin
            STOP_CMD.alarm <= 1'b1;
            STOP_CMD.stop_req <= 1'b1;
          end
          default:              STOP_CMD.alarm <= 1'b1;
        endcase
      end
    end
  end

  // Network configuration view presented to the option cards.
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      NET_CFG <= '0;
      MULTI_STEP_ENABLE <= 1'b0;
    end
    else if (CLOCK_EN)
    begin
      MULTI_STEP_ENABLE <= MULTI_STEP_REQ && (!NET_REF_ACTIVE || net_ref[0]);
      NET_CFG.node_address    <= node[5:0];
      NET_CFG.field_speed     <= field_speed[2:0];
      NET_CFG.station_address <= station;
      NET_CFG.monitor_e       <= mon_e;
      NET_CFG.monitor_f       <= mon_f;
      if (SECOND_GEN)
      begin
        NET_CFG.frame_bytes <= frame[0] ? 8'h11 : 8'h20;
        NET_CFG.link_mbps   <= link_speed[0] ? 4'h4 : 4'hA;
      end
      else
      begin
        NET_CFG.frame_bytes <= frame[0] ? 8'h20 : 8'h40;
        NET_CFG.link_mbps   <= 4'h0;
      end
    end
  end

  // Interrupts: rising fault edges set sticky bits; set wins over write-one clear.
  logic [`DFS_IRQ_BITS-1:0] fault_now, fault_prev;
  assign fault_now = {comm_fault, BUS_FAULT, opt_fault, ENCODER_LOSS_FAULT, SPEED_DEVIATION_FAULT};
  assign irq_event = fault_now & ~fault_prev;
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      fault_prev <= '0;
      irq_status <= '0;
      IRQ <= 1'b0;
    end
    else if (CLOCK_EN)
    begin
      fault_prev <= fault_now;
      if (wr_go && idx == `DFS_IDX_IRQ_STATUS)
        irq_status <= (irq_status & ~wd[`DFS_IRQ_BITS-1:0]) | irq_event;
      else
        irq_status <= irq_status | irq_event;
      IRQ <= |(irq_status & irq_mask);
    end
  end

  always_comb
  begin
    next_prdata = '0;
    case (idx)
      `DFS_IDX_DEV_LEVEL:   next_prdata[15:0] = dev_level;
      `DFS_IDX_DEV_DELAY:   next_prdata[15:0] = dev_delay;
      `DFS_IDX_ENC_TIME:    next_prdata[15:0] = enc_time;
      `DFS_IDX_COMM_ACT:    next_prdata[15:0] = comm_act;
      `DFS_IDX_OPT_MODE:    next_prdata[15:0] = opt_mode;
      `DFS_IDX_OPT_ACT:     next_prdata[15:0] = opt_act;
      `DFS_IDX_BUS_DELAY:   next_prdata[15:0] = bus_delay;
      `DFS_IDX_NET_REF:     next_prdata[15:0] = net_ref;
      `DFS_IDX_RESET_SEL:   next_prdata[15:0] = reset_sel;
      `DFS_IDX_NODE:        next_prdata[15:0] = node;
      `DFS_IDX_FIELD_SPEED: next_prdata[15:0] = field_speed;
      `DFS_IDX_AUTO_RESET:  next_prdata[15:0] = auto_reset;
      `DFS_IDX_STATION:     next_prdata[15:0] = station;
      `DFS_IDX_FRAME:       next_prdata[15:0] = frame;
      `DFS_IDX_LINK_SPEED:  next_prdata[15:0] = link_speed;
      `DFS_IDX_MON_E:       next_prdata[15:0] = mon_e;
      `DFS_IDX_MON_F:       next_prdata[15:0] = mon_f;
      `DFS_IDX_IRQ_STATUS:  next_prdata[`DFS_IRQ_BITS-1:0] = irq_status;
      `DFS_IDX_IRQ_MASK:    next_prdata[`DFS_IRQ_BITS-1:0] = irq_mask;
      `DFS_IDX_FAULT_STATE: next_prdata[`DFS_IRQ_BITS-1:0] = fault_now;
      default:              next_prdata = '0;
    endcase
  end

  // APB slave: data latched in setup, ready asserted through the access phase.
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else if (CLOCK_EN)
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      if (rd_go)
        PRDATA <= next_prdata;
    end
  end

  chk_dev_needs_delay: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(SPEED_DEVIATION_FAULT) |-> $past(dev_excess) && $past(dev_cnt) >= TW'(dev_delay) * TW'(TENTH_CYCLES))
    else $error("Deviation fault raised early.");
  chk_enc_pulse_clears: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CLOCK_EN && ENCODER_PULSE |=> enc_cnt == '0)
    else $error("Encoder timer not restarted.");
  chk_enc_loss_cause: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(ENCODER_LOSS_FAULT) |-> !$past(ENCODER_PULSE))
    else $error("Encoder loss fault with pulse.");
  chk_bus_auto_off: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CLOCK_EN && BUS_FAULT && !BUS_ERROR_RAW && !auto_reset[0] && !FAULT_RESET |=> BUS_FAULT)
    else $error("Bus fault cleared without auto reset.");
  chk_opt_run_only: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CLOCK_EN && opt_mode[0] && !MOTOR_RUNNING && OPTION_EXTERNAL_FAULT && !opt_fault |=> !opt_fault)
    else $error("Option fault taken while stopped.");
  chk_fast_decel_sel: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    STOP_CMD.use_fast_decel |-> STOP_CMD.action == DFS_ACT_FAST)
    else $error("Fast decel without fast stop.");
  chk_multi_step_gate: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CLOCK_EN && NET_REF_ACTIVE && !net_ref[0] |=> !MULTI_STEP_ENABLE)
    else $error("Multi-step applied with network reference.");
  chk_frame_decode: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CLOCK_EN && SECOND_GEN && !frame[0] ##1 CLOCK_EN |-> NET_CFG.frame_bytes == 8'h20)
    else $error("Frame size decode wrong.");
endmodule

// file: tb/dfs_net_partner.sv
// Purpose: Far-side model of the network option card and the encoder feedback.
// Assumes: Requests from the bench change just after rising edges.
// Notes: A comm error goes out as one pulse for each rising request, as a link error would.
`timescale 1ns/1ns
module dfs_net_partner
(
  input  wire logic CLOCK,
  input  wire logic ARST_N,
  input  wire logic pulse_on,
  input  wire logic opt_req,
  input  wire logic comm_req,
  input  wire logic bus_req,
  output logic      encoder_pulse,
  output logic      option_fault,
  output logic      comm_error,
  output logic      bus_error
);
  logic [1:0] phase;
  logic       comm_q;
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      phase         <= 2'h0;
      encoder_pulse <= 1'b0;
      option_fault  <= 1'b0;
      comm_q        <= 1'b0;
      comm_error    <= 1'b0;
      bus_error     <= 1'b0;
    end
    else
    begin
      phase         <= phase + 2'h1;
      encoder_pulse <= pulse_on && (phase == 2'h0);
      option_fault  <= opt_req;
      comm_q        <= comm_req;
      comm_error    <= comm_req && !comm_q;
      bus_error     <= bus_req;
    end
  end
endmodule

// file: tb/dfs_supervisor_tb_top.sv
// Purpose: Self-checking bench for the fault supervision block.
// Assumes: One tenth of a second is shortened to 10 clock cycles.
// Notes: Faults are latched, so the encoder scenario and each option and comm action step clear them first.
`timescale 1ns/1ns
`include "dfs_defs.svh"
module dfs_supervisor_tb_top
  import dfs_pkg::*;
;
  logic            CLOCK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR;
  logic [11:0]     PADDR = 12'h000;
  logic [31:0]     PWDATA = 32'h0, PRDATA, rv;
  logic [15:0]     ms = 16'h01F4;
  logic            run = 1, fres = 0, nref = 0, mreq = 0, gen2 = 0, pon = 1, oreq = 0, creq = 0, breq = 0;
  logic            enc, optf, comm, buse, sdf, elf, busf, mse, irq;
  dfs_stop_type    stop;
  dfs_net_cfg_type cfg;
  int              err_count = 0, cmp_count = 0;
  logic [11:0]     ia [17] = '{`DFS_IDX_RESET_SEL, `DFS_IDX_STATION, `DFS_IDX_FRAME, `DFS_IDX_LINK_SPEED,
    `DFS_IDX_MON_E, `DFS_IDX_DEV_LEVEL, `DFS_IDX_DEV_DELAY, `DFS_IDX_ENC_TIME, `DFS_IDX_COMM_ACT,
    `DFS_IDX_OPT_MODE, `DFS_IDX_OPT_ACT, `DFS_IDX_BUS_DELAY, `DFS_IDX_NET_REF, `DFS_IDX_AUTO_RESET,
    `DFS_IDX_NODE, `DFS_IDX_FIELD_SPEED, 12'h100};
  logic [15:0]     ea [17] = '{0, 16'h15, 0, 0, 0, 16'hA, 16'h5, 16'h14, 1, 0, 1, 16'h14, 0, 0, 0, 0, 0};
  dfs_supervisor #(.TENTH_CYCLES(10), .SPEED_W(16)) DUT (.CLOCK(CLOCK), .ARST_N(ARST_N), .CLOCK_EN(1'b1),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PRDATA(PRDATA), .PSLVERR(PSLVERR), .MOTOR_SPEED(ms), .FREQ_REFERENCE(16'h01F4),
    .MAX_OUTPUT_FREQUENCY(16'h03E8), .ENCODER_PULSE(enc), .MOTOR_RUNNING(run), .OPTION_EXTERNAL_FAULT(optf),
    .COMM_ERROR(comm), .BUS_ERROR_RAW(buse), .FAULT_RESET(fres), .NET_REF_ACTIVE(nref),
    .MULTI_STEP_REQ(mreq), .SECOND_GEN(gen2), .SPEED_DEVIATION_FAULT(sdf), .ENCODER_LOSS_FAULT(elf),
    .BUS_FAULT(busf), .STOP_CMD(stop), .MULTI_STEP_ENABLE(mse), .NET_CFG(cfg), .IRQ(irq));
  dfs_net_partner PEER (.CLOCK(CLOCK), .ARST_N(ARST_N), .pulse_on(pon), .opt_req(oreq), .comm_req(creq),
    .bus_req(breq), .encoder_pulse(enc), .option_fault(optf), .comm_error(comm), .bus_error(buse));
  initial
  begin
    forever #4 CLOCK = ~CLOCK;
  end
  task print_verdict;
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The request stands until the rising edge at which ready is sampled high.
  task apb(input logic w, input logic [11:0] idx, input logic [15:0] d);
    int n;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {idx[9:0], 2'b00};
    PWDATA <= {16'h0000, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge CLOCK);
      if (PREADY === 1'b1)
        break;
    end
    if (n == 20)
    begin
      err_count++;
      print_verdict;
    end
    rv = PRDATA;
    chk(PSLVERR, 32'h0);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task frst;
    @(posedge CLOCK) fres <= 1'b1;
    @(posedge CLOCK) fres <= 1'b0;
  endtask
  task t_reset_values;
    for (int i = 0; i < 17; i++)
    begin
      apb(0, ia[i], 16'h0);
      chk(rv, {16'h0, ea[i]});
    end
    chk(cfg.station_address, 16'h15);
    chk(cfg.frame_bytes, 8'h40);
  endtask
  task t_limits;
    apb(1, `DFS_IDX_NODE, 16'h3F);
    apb(1, `DFS_IDX_NODE, 16'h40);
    apb(1, `DFS_IDX_FIELD_SPEED, 16'h4);
    apb(1, `DFS_IDX_FIELD_SPEED, 16'h5);
    apb(1, `DFS_IDX_MON_F, 16'hFFFF);
    apb(0, `DFS_IDX_MON_F, 16'h0);
    chk(rv, 32'hFFFF);
    cyc(2);
    chk(cfg.node_address, 6'h3F);
    chk(cfg.field_speed, 3'h4);
  endtask
  task t_deviation;
    apb(1, `DFS_IDX_DEV_DELAY, 16'h1);
    apb(1, `DFS_IDX_IRQ_MASK, 16'h0);
    @(posedge CLOCK) ms <= 16'h02BC;
    cyc(8);
    @(posedge CLOCK) ms <= 16'h01F4;
    cyc(2);
    @(posedge CLOCK) ms <= 16'h02BC;
    cyc(8);
    chk(sdf, 0);
    cyc(8);
    chk(sdf, 1);
    chk(irq, 0);
    apb(1, `DFS_IDX_IRQ_MASK, 16'h1);
    cyc(2);
    chk(irq, 1);
    apb(1, `DFS_IDX_IRQ_STATUS, 16'h1);
    cyc(2);
    chk(irq, 0);
    @(posedge CLOCK) ms <= 16'h01F4;
    frst;
  endtask
  task t_encoder;
    apb(1, `DFS_IDX_ENC_TIME, 16'h1);
    frst;
    cyc(20);
    chk(elf, 0);
    @(posedge CLOCK) pon <= 1'b0;
    cyc(20);
    chk(elf, 1);
    @(posedge CLOCK) pon <= 1'b1;
    frst;
  endtask
  task t_option;
    apb(1, `DFS_IDX_OPT_MODE, 16'h1);
    apb(1, `DFS_IDX_IRQ_STATUS, 16'h1F);
    @(posedge CLOCK) run <= 1'b0;
    @(posedge CLOCK) oreq <= 1'b1;
    cyc(3);
    apb(0, `DFS_IDX_IRQ_STATUS, 16'h0);
    chk(rv[2], 0);
    @(posedge CLOCK) run <= 1'b1;
    cyc(3);
    apb(0, `DFS_IDX_IRQ_STATUS, 16'h0);
    chk(rv[2], 1);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge CLOCK) oreq <= 1'b0;
      frst;
      apb(1, `DFS_IDX_OPT_ACT, c[15:0]);
      @(posedge CLOCK) oreq <= 1'b1;
      cyc(3);
      chk(stop.action, c[2:0]);
      chk(stop.stop_req, c != 3);
      chk(stop.alarm, c == 3);
      chk(stop.use_fast_decel, c == 2);
    end
    @(posedge CLOCK) oreq <= 1'b0;
  endtask
  task t_comm;
    for (int c = 0; c < 6; c++)
    begin
      frst;
      apb(1, `DFS_IDX_COMM_ACT, c[15:0]);
      @(posedge CLOCK) creq <= 1'b1;
      cyc(3);
      chk(stop.action, c[2:0]);
      chk(stop.stop_req, c < 3 || c == 5);
      chk(stop.alarm, c > 2);
      chk(stop.run_preset_four, c == 4);
      chk(stop.use_fast_decel, c == 2);
      @(posedge CLOCK) creq <= 1'b0;
    end
  endtask
  task t_bus;
    apb(1, `DFS_IDX_BUS_DELAY, 16'h1);
    @(posedge CLOCK) breq <= 1'b1;
    cyc(5);
    chk(busf, 0);
    cyc(12);
    chk(busf, 1);
    @(posedge CLOCK) breq <= 1'b0;
    cyc(3);
    chk(busf, 1);
    apb(1, `DFS_IDX_AUTO_RESET, 16'h1);
    cyc(3);
    chk(busf, 0);
  endtask
  task t_config;
    @(posedge CLOCK) gen2 <= 1'b1;
    apb(1, `DFS_IDX_LINK_SPEED, 16'h1);
    cyc(2);
    chk(cfg.frame_bytes, 8'h20);
    chk(cfg.link_mbps, 4'h4);
    apb(1, `DFS_IDX_FRAME, 16'h1);
    cyc(2);
    chk(cfg.frame_bytes, 8'h11);
    @(posedge CLOCK) gen2 <= 1'b0;
    cyc(2);
    chk(cfg.frame_bytes, 8'h20);
    chk(cfg.link_mbps, 4'h0);
    @(posedge CLOCK) {nref, mreq} <= 2'b11;
    cyc(2);
    chk(mse, 0);
    apb(1, `DFS_IDX_NET_REF, 16'h1);
    cyc(2);
    chk(mse, 1);
  endtask
  task t_init;
    apb(1, `DFS_IDX_NODE, 16'h7);
    apb(1, `DFS_IDX_INIT_CMD, 16'h1);
    apb(0, `DFS_IDX_NODE, 16'h0);
    chk(rv, 32'h7);
    apb(1, `DFS_IDX_RESET_SEL, 16'h1);
    apb(1, `DFS_IDX_INIT_CMD, 16'h1);
    apb(0, `DFS_IDX_NODE, 16'h0);
    chk(rv, 32'h0);
    apb(0, `DFS_IDX_RESET_SEL, 16'h0);
    chk(rv, 32'h0);
  endtask
  initial
  begin
    repeat (2) @(posedge CLOCK);
    ARST_N <= 1'b1;
    t_reset_values;
    t_limits;
    t_deviation;
    t_encoder;
    t_option;
    t_comm;
    t_bus;
    t_config;
    t_init;
    print_verdict;
  end
endmodule
